/* rtl/psf_defines.vh */
// Register map, field positions, mode codes and timing counts of the pressure sample buffer.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef PSF_DEFINES_VH
`define PSF_DEFINES_VH

// Register addresses (7-bit register space)
`define PSF_ADDR_CTRL_TWO   7'h21
`define PSF_ADDR_IRQ_ROUTE  7'h23
`define PSF_ADDR_TRIG_CFG   7'h24
`define PSF_ADDR_RES_LOW    7'h28
`define PSF_ADDR_RES_MID    7'h29
`define PSF_ADDR_RES_HIGH   7'h2A
`define PSF_ADDR_BUF_CTRL   7'h2E
`define PSF_ADDR_BUF_STATE  7'h2F

// Reset values
`define PSF_RST_CTRL_TWO    8'h00
`define PSF_RST_IRQ_ROUTE   8'h00
`define PSF_RST_TRIG_CFG    8'h00
`define PSF_RST_BUF_CTRL    8'h00

// Sub-address auto-increment bit
`define PSF_SUB_AUTOINC     7

// control_two fields
`define PSF_C2_BUF_ENABLE   6
`define PSF_C2_STOP_ON_THR  5
`define PSF_C2_MEAN_DEC     4

// buffer_control fields
`define PSF_BC_MODE_HI      7
`define PSF_BC_MODE_LO      5
`define PSF_BC_WTM_HI       4
`define PSF_BC_WTM_LO       0

// buffer_state fields
`define PSF_BS_WTM          7
`define PSF_BS_OVERRUN      6
`define PSF_BS_EMPTY        5

// interrupt_routing_control fields
`define PSF_IR_READY        0
`define PSF_IR_OVERRUN      1
`define PSF_IR_WTM          2
`define PSF_IR_EMPTY        3

// Buffer mode codes
`define PSF_MODE_BYPASS     3'h0
`define PSF_MODE_FIFO       3'h1
`define PSF_MODE_STREAM     3'h2
`define PSF_MODE_STR2FIFO   3'h3
`define PSF_MODE_BYP2STR    3'h4
`define PSF_MODE_MEAN       3'h6
`define PSF_MODE_BYP2FIFO   3'h7

// Output rate codes that allow mean decimation, and averaged outputs per kept output
`define PSF_RATE_7HZ        3'h2
`define PSF_RATE_12HZ       3'h3
`define PSF_RATE_25HZ       3'h4
`define PSF_DEC_7HZ         5'h07
`define PSF_DEC_12HZ        5'h0C
`define PSF_DEC_25HZ        5'h19

`endif

/* rtl/psf_pressure_buffer.v */
// Pressure sample buffer: 32-slot store, mode control, mean filter and result registers.
// Assumes a serial engine that presents byte accesses on the acc* port and a conversion
// chain that offers 24-bit results with valid/ready; one 40 MHz clock, async reset.
//
// Operation
// - Store up to 32 complete 24-bit pressure results.
// - Buffer runs only when enabled; three-bit mode field selects behaviour.
// - Status shows threshold, overrun, unread count; routable to interrupt pin.
// - Bypass mode stores nothing and stays empty.
// - Fill-and-stop mode collects until 32 entries, then drops new results.
// - With stop-on-threshold set, flag when fill level reaches watermark.
// - Stream mode overwrites oldest entry when full; watermark as before.
// - Mode 011 streams until trigger, then behaves as fill-and-stop.
// - Mode 100 bypasses until trigger, then streams.
// - Mode 111 bypasses until trigger, then fill-and-stop.
// - Mean mode stores results and outputs their moving average.
// - Watermark field selects averaging window of 2, 4, 8, 16, 32.
// - Mean decimation gives about one output per second for rate codes 2-4.
// - In mean mode stored entries are not readable, only the average.
// - Each buffer read loads the oldest entry into the result registers.
// - Auto-incrementing reads wrap from the high result byte back to low.
// - A data-ready flag marks each newly available result.
`include "psf_defines.vh"

module psf_pressure_buffer #(
  parameter DEPTH = 32,
  parameter AW    = 5,
  parameter DW    = 24
) (
  input  wire          sys_clk,
  input  wire          rst_b,
  input  wire          smpValid,
  input  wire [DW-1:0] smpData,
  output wire          smpReady,
  input  wire [2:0]    outputRateCode,
  input  wire          trigEvent,
  input  wire          accStart,
  input  wire [7:0]    accSub,
  input  wire          accWrite,
  input  wire [7:0]    accWdata,
  input  wire          accRead,
  output reg  [7:0]    accRdata,
  output reg  [7:0]    trigConfig,
  output reg           dataReady,
  output reg           irqReadyPin
);

  // Behaviour codes after trigger resolution
  localparam BH_BYPASS = 2'h0;
  localparam BH_STOP   = 2'h1;
  localparam BH_STREAM = 2'h2;
  localparam BH_MEAN   = 2'h3;
  localparam SW        = DW + AW;

  reg  [7:0]    controlTwo;
  reg  [7:0]    irqRoute;
  reg  [7:0]    bufControl;
  reg  [6:0]    addrPtr;
  reg           autoInc;
  reg  [DW-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0] wrPtr;
  reg  [AW-1:0] rdPtr;
  reg  [AW:0]   count;
  reg  [SW-1:0] sum;
  reg  [DW-1:0] result;
  reg           triggered;
  reg           overrun;
  reg           wtmFlag;
  reg  [4:0]    decimCnt;
  reg  [1:0]    behaviour;
  reg  [2:0]    avgShift;
  reg  [4:0]    decimLimit;
  reg  [SW-1:0] next_sum;
  reg  [6:0]    next_ptr;
  reg  [7:0]    readByte;

  wire          bufValid;
  wire [DW-1:0] bufData;
  wire          bufReady;
  wire          push;
  wire          popReq;
  wire          enabled;
  wire          flush;
  wire [2:0]    mode;
  wire [4:0]    wtmLevel;
  wire [AW:0]   window;
  wire          full;
  wire          windowFull;
  wire          meanUpdate;
  wire          queueView;
  wire [SW-1:0] meanVal;

  assign enabled  = controlTwo[`PSF_C2_BUF_ENABLE];
  assign mode     = bufControl[`PSF_BC_MODE_HI:`PSF_BC_MODE_LO];
  assign wtmLevel = bufControl[`PSF_BC_WTM_HI:`PSF_BC_WTM_LO];
  assign full     = (count == DEPTH[AW:0]);

  // Results enter through a two-entry buffer so a host pop never loses a sample
  psf_skid_buffer #(
    .DW (DW)
  ) u_skid (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .inValid  (smpValid),
    .inData   (smpData),
    .inReady  (smpReady),
    .outValid (bufValid),
    .outData  (bufData),
    .outReady (bufReady)
  );

  // Mode resolution including trigger-switched modes
  always @* begin
    if (!enabled) begin
      behaviour = BH_BYPASS;
    end else begin
      case (mode)
        `PSF_MODE_FIFO:     behaviour = BH_STOP;
        `PSF_MODE_STREAM:   behaviour = BH_STREAM;
        `PSF_MODE_STR2FIFO: behaviour = triggered ? BH_STOP : BH_STREAM;
        `PSF_MODE_BYP2STR:  behaviour = triggered ? BH_STREAM : BH_BYPASS;
        `PSF_MODE_BYP2FIFO: behaviour = triggered ? BH_STOP : BH_BYPASS;
        `PSF_MODE_MEAN:     behaviour = BH_MEAN;
        default:            behaviour = BH_BYPASS;
      endcase
    end
  end

  // Averaging window from the watermark field; values other than 3, 7, 15 and 31 fall back to two samples
  always @* begin
    case (wtmLevel)
      5'h03:   avgShift = 3'h2;
      5'h07:   avgShift = 3'h3;
      5'h0F:   avgShift = 3'h4;
      5'h1F:   avgShift = 3'h5;
      default: avgShift = 3'h1;
    endcase
  end
  assign window = {{AW{1'b0}}, 1'b1} << avgShift;

  // Decimation length per output rate; other rates are not decimated
  always @* begin
    case (outputRateCode)
      `PSF_RATE_7HZ:  decimLimit = `PSF_DEC_7HZ;
      `PSF_RATE_12HZ: decimLimit = `PSF_DEC_12HZ;
      `PSF_RATE_25HZ: decimLimit = `PSF_DEC_25HZ;
      default:        decimLimit = 5'h01;
    endcase
  end

  // Sample acceptance and pop; a pop stalls the input side for one cycle
  assign queueView = (behaviour == BH_STOP) || (behaviour == BH_STREAM);
  assign popReq    = accRead && (addrPtr == `PSF_ADDR_RES_HIGH) && queueView
                     && (count != {(AW+1){1'b0}});
  assign bufReady  = !popReq;
  assign push      = bufValid & bufReady;

  // Mode change or disable empties the buffer
  assign flush = !enabled
                 || (accWrite && addrPtr == `PSF_ADDR_BUF_CTRL
                     && accWdata[`PSF_BC_MODE_HI:`PSF_BC_MODE_LO] != mode);

  // Running sum drops the sample leaving the window
  assign windowFull = (count >= window);
  always @* begin
    next_sum = sum + {{AW{1'b0}}, bufData};
    if (windowFull)
      next_sum = next_sum - {{AW{1'b0}}, mem[rdPtr]};
  end
  assign meanUpdate = push && (behaviour == BH_MEAN) && (count + 1'b1 >= window);
  assign meanVal    = next_sum >> avgShift; // Shift first, the top bits are then zero unless the window shrinks without a mode change

  // Sample store: write side, read side and occupancy
  always @(posedge sys_clk) begin
    if (push && behaviour != BH_BYPASS && !(behaviour == BH_STOP && full))
      mem[wrPtr] <= bufData;
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr     <= {AW{1'b0}};
      rdPtr     <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      sum       <= {SW{1'b0}};
      overrun   <= 1'b0;
      triggered <= 1'b0;
    end else if (flush) begin
      wrPtr     <= {AW{1'b0}};
      rdPtr     <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      sum       <= {SW{1'b0}};
      overrun   <= 1'b0;
      triggered <= 1'b0;
    end else begin
      if (trigEvent)
        triggered <= 1'b1;
      if (popReq) begin
        rdPtr <= rdPtr + 1'b1;
        count <= count - 1'b1;
      end else if (push) begin
        case (behaviour)
          BH_STOP: begin
            if (full) begin
              overrun <= 1'b1;
            end else begin
              wrPtr <= wrPtr + 1'b1;
              count <= count + 1'b1;
            end
          end
          BH_STREAM: begin
            wrPtr <= wrPtr + 1'b1;
            if (full) begin
              rdPtr   <= rdPtr + 1'b1;
              overrun <= 1'b1;
            end else begin
              count <= count + 1'b1;
            end
          end
          BH_MEAN: begin
            wrPtr <= wrPtr + 1'b1;
            sum   <= next_sum;
            if (windowFull)
              rdPtr <= rdPtr + 1'b1;
            else
              count <= count + 1'b1;
          end
          default: begin
            count <= {(AW+1){1'b0}};
          end
        endcase
      end
    end
  end

  // Watermark flag follows fill level only when stop-on-threshold is set
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      wtmFlag <= 1'b0;
    else
      wtmFlag <= !flush && controlTwo[`PSF_C2_STOP_ON_THR] && queueView
                 && (count >= {1'b0, wtmLevel});
  end

  // Result registers: direct, queue head or average depending on behaviour
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      result   <= {DW{1'b0}};
      decimCnt <= 5'h00;
    end else begin
      case (behaviour)
        BH_STOP, BH_STREAM: begin
          // Head is re-read each cycle, so a pop shows up two cycles later
          if (count != {(AW+1){1'b0}})
            result <= mem[rdPtr];
        end
        BH_MEAN: begin
          if (meanUpdate) begin
            if (!controlTwo[`PSF_C2_MEAN_DEC] || decimCnt + 5'h01 >= decimLimit) begin
              result   <= meanVal[DW-1:0];
              decimCnt <= 5'h00;
            end else begin
              decimCnt <= decimCnt + 5'h01;
            end
          end
        end
        default: begin
          if (push)
            result <= bufData;
        end
      endcase
    end
  end

  // Data-ready: a new result wins over a simultaneous clear by reading the high byte
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      dataReady <= 1'b0;
    else if (push)
      dataReady <= 1'b1;
    else if (accRead && addrPtr == `PSF_ADDR_RES_HIGH)
      dataReady <= 1'b0;
  end

  // Interrupt routing onto the shared ready pin
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      irqReadyPin <= 1'b0;
    else
      irqReadyPin <= (irqRoute[`PSF_IR_READY] & dataReady)
                     | (irqRoute[`PSF_IR_OVERRUN] & overrun)
                     | (irqRoute[`PSF_IR_WTM] & wtmFlag)
                     | (irqRoute[`PSF_IR_EMPTY] & queueView
                        & (count == {(AW+1){1'b0}}));
  end

  // Address pointer advance; the result bytes form a closed loop
  always @* begin
    if (addrPtr == `PSF_ADDR_RES_HIGH)
      next_ptr = `PSF_ADDR_RES_LOW;
    else
      next_ptr = addrPtr + 7'h01;
  end

  // Byte access pointer taken from the sub-address at the start of each access
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addrPtr <= 7'h00;
      autoInc <= 1'b0;
    end else if (accStart) begin
      addrPtr <= accSub[6:0];
      autoInc <= accSub[`PSF_SUB_AUTOINC];
    end else if ((accRead || accWrite) && autoInc) begin
      addrPtr <= next_ptr;
    end
  end

  // Writable registers
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      controlTwo <= `PSF_RST_CTRL_TWO;
      irqRoute   <= `PSF_RST_IRQ_ROUTE;
      trigConfig <= `PSF_RST_TRIG_CFG;
      bufControl <= `PSF_RST_BUF_CTRL;
    end else if (accWrite) begin
      case (addrPtr)
        `PSF_ADDR_CTRL_TWO:  controlTwo <= accWdata;
        `PSF_ADDR_IRQ_ROUTE: irqRoute   <= accWdata;
        `PSF_ADDR_TRIG_CFG:  trigConfig <= accWdata;
        `PSF_ADDR_BUF_CTRL:  bufControl <= accWdata;
        default:             controlTwo <= controlTwo;
      endcase
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always @* begin
    case (addrPtr)
      `PSF_ADDR_CTRL_TWO:  readByte = controlTwo;
      `PSF_ADDR_IRQ_ROUTE: readByte = irqRoute;
      `PSF_ADDR_TRIG_CFG:  readByte = trigConfig;
      `PSF_ADDR_RES_LOW:   readByte = result[7:0];
      `PSF_ADDR_RES_MID:   readByte = result[15:8];
      `PSF_ADDR_RES_HIGH:  readByte = result[23:16];
      `PSF_ADDR_BUF_CTRL:  readByte = bufControl;
      `PSF_ADDR_BUF_STATE: readByte = {wtmFlag, overrun,
                                       queueView ? (count == {(AW+1){1'b0}}) : 1'b1,
                                       queueView ? count[4:0] : 5'h00};
      default:             readByte = 8'h00;
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      accRdata <= 8'h00;
    else if (accRead)
      accRdata <= readByte;
  end

endmodule // psf_pressure_buffer

/* rtl/psf_skid_buffer.v */
// Two-entry valid/ready buffer for conversion results on their way into the sample store.
// Assumes one clock and an active-low asynchronous reset; both sides on that clock.
module psf_skid_buffer #(
  parameter DW = 24
) (
  input  wire          sys_clk,
  input  wire          rst_b,
  input  wire          inValid,
  input  wire [DW-1:0] inData,
  output reg           inReady,
  output reg           outValid,
  output wire [DW-1:0] outData,
  input  wire          outReady
);

  reg  [DW-1:0] slot0;
  reg  [DW-1:0] slot1;
  reg  [1:0]    fill;
  wire          take;
  wire          give;
  reg  [1:0]    next_fill;

  assign take    = inValid & inReady;
  assign give    = outValid & outReady;
  assign outData = slot0;

  // Occupancy after this cycle
  always @* begin
    next_fill = fill;
    if (take && !give)
      next_fill = fill + 2'h1;
    else if (give && !take)
      next_fill = fill - 2'h1;
  end

  // Slot 0 is always the head; ready and valid kept as flops to keep ports glitch free
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      slot0    <= {DW{1'b0}};
      slot1    <= {DW{1'b0}};
      fill     <= 2'h0;
      inReady  <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (give) begin
        slot0 <= (fill == 2'h2) ? slot1 : inData;
        if (take && fill == 2'h2)
          slot1 <= inData;
      end else if (take) begin
        if (fill == 2'h0)
          slot0 <= inData;
        else
          slot1 <= inData;
      end
      fill     <= next_fill;
      inReady  <= (next_fill != 2'h2);
      outValid <= (next_fill != 2'h0);
    end
  end

endmodule // psf_skid_buffer

/* tb/psf_host_model.sv */
// Host register master: sub-address, byte writes and byte reads.
// Assumes the bench clock; strobes change just after a rising edge.
module psf_host_model (
  input  wire       sys_clk,
  output reg        accStart,
  output reg  [7:0] accSub,
  output reg        accWrite,
  output reg  [7:0] accWdata,
  output reg        accRead
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    accStart = 1'b0;
    accSub   = 8'h00;
    accWrite = 1'b0;
    accWdata = 8'h00;
    accRead  = 1'b0;
  end
  // Each strobe lasts one cycle, then one idle cycle
  task start(input logic [6:0] a, input logic inc);
    @(posedge sys_clk);
    accStart <= 1'b1;
    accSub   <= {inc, a};
    @(posedge sys_clk);
    accStart <= 1'b0;
  endtask
  task wr(input logic [7:0] d);
    @(posedge sys_clk);
    accWrite <= 1'b1;
    accWdata <= d;
    @(posedge sys_clk);
    accWrite <= 1'b0;
    accWdata <= ~d; // Stale byte never lingers
  endtask
  task rd;
    @(posedge sys_clk);
    accRead <= 1'b1;
    @(posedge sys_clk);
    accRead <= 1'b0;
  endtask
endmodule // psf_host_model

/* tb/psf_props.sv */
// Checker on the pressure buffer's register and sample ports.
// Assumes a bind onto psf_pressure_buffer; mirrors pointer and RW registers.
module psf_props #(
  parameter DEPTH = 32,
  parameter AW    = 5,
  parameter DW    = 24
) (
  input wire          sys_clk,
  input wire          rst_b,
  input wire          smpValid,
  input wire [DW-1:0] smpData,
  input wire          smpReady,
  input wire [2:0]    outputRateCode,
  input wire          trigEvent,
  input wire          accStart,
  input wire [7:0]    accSub,
  input wire          accWrite,
  input wire [7:0]    accWdata,
  input wire          accRead,
  input wire [7:0]    accRdata,
  input wire [7:0]    trigConfig,
  input wire          dataReady,
  input wire          irqReadyPin
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [6:0] ptr;
  reg        autoInc;
  reg  [7:0] ctrlTwo;
  reg  [7:0] irqRoute;
  reg  [7:0] bufCtrl;
  wire [2:0] mode   = bufCtrl[7:5];
  wire       take   = smpValid && smpReady;
  wire       cfgWr  = accWrite && ptr == 7'h24;
  wire       isRw   = ptr == 7'h21 || ptr == 7'h23 || ptr == 7'h2E;
  wire       mapped = isRw || ptr == 7'h24 || ptr == 7'h2F || (ptr >= 7'h28 && ptr <= 7'h2A);
  wire [7:0] shadow = ptr == 7'h21 ? ctrlTwo : (ptr == 7'h23 ? irqRoute : bufCtrl);
  // Mean and bypass-like modes keep the queue empty
  wire       idle   = !ctrlTwo[6] || mode == 3'h0 || mode == 3'h5 || mode == 3'h6;

  // Pointer mirror; the high result byte wraps back to the low one
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr      <= 7'h00;
      autoInc  <= 1'b0;
      ctrlTwo  <= 8'h00;
      irqRoute <= 8'h00;
      bufCtrl  <= 8'h00;
    end else begin
      if (accStart) begin
        ptr     <= accSub[6:0];
        autoInc <= accSub[7];
      end else if ((accRead || accWrite) && autoInc) begin
        ptr <= (ptr == 7'h2A) ? 7'h28 : ptr + 7'h01;
      end
      if (accWrite && ptr == 7'h21) ctrlTwo <= accWdata;
      if (accWrite && ptr == 7'h23) irqRoute <= accWdata;
      if (accWrite && ptr == 7'h2E) bufCtrl <= accWdata;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_cfgWrite;
    cfgWr;
  endsequence
  sequence s_popRead;
    accRead && ptr == 7'h2A && !smpValid;
  endsequence
  property p_rdHold;
    !$past(accRead) |-> $stable(accRdata);
  endproperty
  property p_unmapped;
    accRead && !mapped |=> accRdata == 8'h00;
  endproperty
  property p_cfgLoad;
    s_cfgWrite |=> trigConfig == $past(accWdata);
  endproperty
  property p_cfgOnly;
    !$stable(trigConfig) |-> $past(cfgWr);
  endproperty
  property p_rwBack;
    accRead && isRw |=> accRdata == $past(shadow);
  endproperty
  property p_idleState;
    accRead && ptr == 7'h2F && idle && $past(idle) && $past(idle, 2)
      |=> (accRdata & 8'hBF) == 8'h20;
  endproperty
  property p_stateShape;
    accRead && ptr == 7'h2F |=> !(accRdata[5] && accRdata[4:0] != 5'h00);
  endproperty
  property p_readyRise;
    $rose(dataReady) |-> $past(take) || $past(take, 2) || $past(take, 3) || $past(take, 4);
  endproperty
  property p_readyClear;
    s_popRead ##0 (!$past(smpValid) && !$past(smpValid, 2) && !$past(smpValid, 3))
      |=> !dataReady;
  endproperty
  property p_irqQuiet;
    irqRoute == 8'h00 && $past(irqRoute) == 8'h00 |-> !irqReadyPin;
  endproperty

  a_rdHold: assert property (p_rdHold)
    else $error("read byte moved");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_cfgLoad: assert property (p_cfgLoad)
    else $error("trigger config not loaded");
  a_cfgOnly: assert property (p_cfgOnly)
    else $error("trigger config moved");
  a_rwBack: assert property (p_rwBack)
    else $error("readback differs");
  a_idleState: assert property (p_idleState)
    else $error("idle status wrong");
  a_stateShape: assert property (p_stateShape)
    else $error("empty with count");
  a_readyRise: assert property (p_readyRise)
    else $error("ready without sample");
  a_readyClear: assert property (p_readyClear)
    else $error("ready not cleared");
  a_irqQuiet: assert property (p_irqQuiet)
    else $error("pin high unrouted");
endmodule // psf_props

bind psf_pressure_buffer psf_props #(.DEPTH(DEPTH), .AW(AW), .DW(DW)) u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .smpValid(smpValid), .smpData(smpData),
  .smpReady(smpReady), .outputRateCode(outputRateCode), .trigEvent(trigEvent),
  .accStart(accStart), .accSub(accSub), .accWrite(accWrite), .accWdata(accWdata),
  .accRead(accRead), .accRdata(accRdata), .trigConfig(trigConfig),
  .dataReady(dataReady), .irqReadyPin(irqReadyPin)
);

/* tb/test_pressure_sample_fifo.sv */
// Self-checking bench: registers, queue modes, drains and mean windows.
// Assumes psf_pressure_buffer, psf_host_model and the bound checker.
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end

module test_pressure_sample_fifo;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        rst_b;
  logic        smpValid;
  logic [23:0] smpData;
  wire         smpReady;
  logic [2:0]  outputRateCode;
  logic        trigEvent;
  wire         accStart;
  wire  [7:0]  accSub;
  wire         accWrite;
  wire  [7:0]  accWdata;
  wire         accRead;
  wire  [7:0]  accRdata;
  wire  [7:0]  trigConfig;
  wire         dataReady;
  wire         irqReadyPin;
  int          fail_count = 0;
  int          comparisons = 0;
  integer      seed = 31;
  int          nIn;
  logic        rdPend = 1'b0;
  logic [7:0]  ex;
  logic [7:0]  expQ[$];
  logic [23:0] ent[0:63];
  logic [6:0]  rwAddr[0:3] = '{7'h21, 7'h23, 7'h24, 7'h2E};

  psf_pressure_buffer dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .smpValid(smpValid), .smpData(smpData),
    .smpReady(smpReady), .outputRateCode(outputRateCode), .trigEvent(trigEvent),
    .accStart(accStart), .accSub(accSub), .accWrite(accWrite), .accWdata(accWdata),
    .accRead(accRead), .accRdata(accRdata), .trigConfig(trigConfig),
    .dataReady(dataReady), .irqReadyPin(irqReadyPin));
  psf_host_model host (
    .sys_clk(sys_clk), .accStart(accStart), .accSub(accSub), .accWrite(accWrite),
    .accWdata(accWdata), .accRead(accRead));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Read data lands a cycle after the strobe; pair it with the oldest note
  always @(posedge sys_clk) begin
    if (rdPend) begin
      ex = expQ.pop_front();
      `CHK(accRdata, ex)
    end
    rdPend <= accRead;
  end

  task automatic rx(input logic [7:0] e);
    expQ.push_back(e);
    host.rd();
  endtask
  task automatic rr(input logic [6:0] a, input logic [7:0] e);
    host.start(a, 1'b0);
    rx(e);
  endtask
  task automatic wx(input logic [6:0] a, input logic [7:0] d);
    host.start(a, 1'b0);
    host.wr(d);
  endtask
  // Result held until taken; bounded wait so a stuck ready cannot hang
  task automatic push(input logic [23:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    smpValid <= 1'b1;
    smpData  <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (smpReady !== 1'b1 && n < 64);
    if (smpReady !== 1'b1) fail_count++; // Stuck input side counts as a failure
    smpValid <= 1'b0;
    smpData  <= ~d;
  endtask
  task automatic fill(input int n);
    repeat (n) begin
      ent[nIn] = 24'($random(seed));
      push(ent[nIn]);
      nIn++;
    end
  endtask
  // Three bytes per entry; the pause lets the next head settle
  task automatic drain(input int first, input int n);
    host.start(7'h28, 1'b1);
    for (int k = first; k < first + n; k++) begin
      rx(ent[k][7:0]);
      rx(ent[k][15:8]);
      rx(ent[k][23:16]);
      repeat (2) @(posedge sys_clk);
    end
  endtask
  task automatic trig;
    @(posedge sys_clk);
    trigEvent <= 1'b1;
    @(posedge sys_clk);
    trigEvent <= 1'b0;
  endtask
  task end_of_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    smpValid = 1'b0;
    smpData = 24'h000000;
    trigEvent = 1'b0;
    outputRateCode = 3'($random(seed));
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    `CHK(smpReady, 1'b1)
    // Reset values, refused writes to status and to an unmapped place
    for (int i = 0; i < 4; i++) rr(rwAddr[i], 8'h00);
    wx(7'h2F, 8'hFF);
    rr(7'h2F, 8'h20);
    wx(7'h30, 8'hFF);
    rr(7'h30, 8'h00);
    wx(7'h24, 8'h5A);
    @(posedge sys_clk);
    `CHK(trigConfig, 8'h5A)
    // Bypass shows results directly; ready flag routed to the pin
    wx(7'h21, 8'h40);
    wx(7'h23, 8'h01);
    push(24'h123456);
    repeat (4) @(posedge sys_clk);
    `CHK(dataReady, 1'b1)
    `CHK(irqReadyPin, 1'b1)
    wx(7'h23, 8'h00);
    host.start(7'h28, 1'b1);
    rx(8'h56);
    rx(8'h34);
    rx(8'h12);
    rr(7'h2F, 8'h20);
    `CHK(dataReady, 1'b0)
    // Fill-and-stop: the 33rd result is dropped, overrun sticks
    wx(7'h21, 8'h60);
    wx(7'h2E, 8'h24);
    nIn = 0;
    fill(33);
    rr(7'h2F, 8'hC0);
    drain(0, 32);
    rr(7'h2F, 8'h60);
    wx(7'h21, 8'h00);
    rr(7'h2F, 8'h20);
    wx(7'h21, 8'h60);
    // Stream: watermark exactly at four, then the oldest two are lost
    wx(7'h2E, 8'h44);
    rr(7'h2F, 8'h20);
    nIn = 0;
    fill(3);
    rr(7'h2F, 8'h03);
    fill(1);
    rr(7'h2F, 8'h84);
    fill(30);
    rr(7'h2F, 8'hC0);
    drain(2, 32);
    // Triggered switches
    wx(7'h2E, 8'h84);
    nIn = 0;
    fill(1);
    rr(7'h2F, 8'h20);
    trig;
    fill(1);
    rr(7'h2F, 8'h01);
    wx(7'h2E, 8'hE4);
    nIn = 0;
    fill(1);
    rr(7'h2F, 8'h20);
    trig;
    fill(33);
    rr(7'h2F, 8'hC0);
    drain(1, 1);
    wx(7'h2E, 8'h64);
    nIn = 0;
    fill(34);
    trig;
    fill(1);
    drain(2, 1);
    // Mean windows 2..32: only the last of n results is non-zero
    for (int w = 1; w <= 5; w++) begin
      wx(7'h2E, 8'h00);
      wx(7'h2E, {3'h6, 5'((1 << w) - 1)});
      repeat ((1 << w) - 1) push(24'h000000);
      push(24'((1 << w) * (1 << w)));
      repeat (4) @(posedge sys_clk);
      host.start(7'h28, 1'b1);
      rx(8'(1 << w));
      rx(8'h00);
      rx(8'h00);
    end
    // Decimated mean at rate code 2: only every seventh average reaches the output
    wx(7'h2E, 8'h00);
    outputRateCode <= 3'h2;
    wx(7'h2E, 8'hC1);
    wx(7'h21, 8'h70);
    repeat (7) push(24'h00ABCD);
    rr(7'h28, 8'h20);
    push(24'h00ABCD);
    rr(7'h28, 8'hCD);
    rr(7'h2F, 8'h20);
    repeat (4) @(posedge sys_clk);
    end_of_test;
  end

  // Whole sequence needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    end_of_test;
  end
endmodule // test_pressure_sample_fifo
